// File: common/flfp_pkg.sv
`default_nettype none
package flfp_pkg;
	// ====================================================================
	// Register map (byte addresses)
	localparam logic [7:0] ADR_CMD = 8'h00;
	localparam logic [7:0] ADR_RDATA = 8'h04;
	localparam logic [7:0] ADR_STATUS = 8'h08;
	localparam logic [7:0] ADR_CFG = 8'h0c;
	// Command word fields
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_ADR_LSB = 8;
	localparam int CMD_DAT_LSB = 16;
	// ====================================================================
	// Opcodes
	localparam logic [7:0] OP_CHIP_ERASE = 8'h8a;
	localparam logic [7:0] OP_LOAD = 8'h51;
	localparam logic [7:0] OP_WR_CODE = 8'h50;
	localparam logic [7:0] OP_WR_CODE_AE = 8'h70;
	localparam logic [7:0] OP_RD_CODE = 8'h30;
	localparam logic [7:0] OP_WR_DATA = 8'hd0;
	localparam logic [7:0] OP_WR_DATA_AE = 8'hd2;
	localparam logic [7:0] OP_RD_DATA = 8'hb0;
	localparam logic [7:0] OP_WR_SIG = 8'h52;
	localparam logic [7:0] OP_WR_SIG_AE = 8'h72;
	localparam logic [7:0] OP_RD_SIG = 8'h32;
	localparam logic [7:0] OP_WR_FUSE = 8'he1;
	localparam logic [7:0] OP_WR_FUSE_AE = 8'hf1;
	localparam logic [7:0] OP_RD_FUSE = 8'h61;
	localparam logic [7:0] OP_WR_LOCK = 8'he4;
	localparam logic [7:0] OP_RD_LOCK = 8'h64;
	// ====================================================================
	// Byte values
	localparam logic [7:0] BYTE_ERASED = 8'hff;
	localparam logic [7:0] BYTE_CLEARED = 8'h00;
	localparam logic [7:0] POLL_ERASE = 8'h7f;
	localparam logic [7:0] MSB_MASK = 8'h80;
	// ====================================================================
	// Fuse row and lock row
	localparam int NUM_FUSES = 12;
	localparam int NUM_LOCKS = 2;
	localparam int FUSE_CS_LO = 0;
	localparam int FUSE_CS_HI = 1;
	localparam int FUSE_SUT_LO = 2;
	localparam int FUSE_SUT_HI = 3;
	localparam int FUSE_RST_PIN = 4;
	localparam int FUSE_BROWNOUT = 5;
	localparam int FUSE_DEBUG = 6;
	localparam int FUSE_SERIAL_PROG = 7;
	localparam int FUSE_SIG_PROG = 8;
	localparam int FUSE_TRISTATE = 9;
	localparam int FUSE_DEBUG_IF = 10;
	localparam int FUSE_APP_WRITE = 11;
	localparam logic [NUM_FUSES-1:0] FUSE_RESET = 12'hfff;
	localparam logic [NUM_LOCKS-1:0] LOCK_RESET = 2'b11;
	// ====================================================================
	// Status and configuration bit positions
	localparam int STAT_BUSY = 0;
	localparam int STAT_REFUSED = 1;
	localparam int STAT_LVL_LSB = 2;
	localparam int STAT_ERASE = 4;
	localparam int CFG_CLK_LSB = 0;
	localparam int CFG_SUT_LSB = 2;
	localparam int CFG_RST_PIN = 4;
	localparam int CFG_BROWNOUT = 5;
	localparam int CFG_DEBUG = 6;
	localparam int CFG_SERIAL_ANY = 7;
	localparam int CFG_SIG_WR = 8;
	localparam int CFG_TRISTATE = 9;
	localparam int CFG_APP_WR = 10;
	// ====================================================================
	// Wake-up delays in microseconds, indexed by startup select
	localparam logic [15:0] SUT_CRYSTAL_OSCILLATOR_US [4] = '{16'h03e8, 16'h07d0, 16'h0fa0, 16'h3e80};
	localparam logic [15:0] SUT_OTHER_US [4] = '{16'h0010, 16'h0200, 16'h03e8, 16'h0fa0};
	// ====================================================================
	// Enumerations
	typedef enum logic [1:0] {
		CLK_CRYSTAL_OSCILLATOR_HS = 2'b00,
		CLK_CRYSTAL_OSCILLATOR_LS = 2'b01,
		CLK_EXTERNAL_CLOCK_INPUT = 2'b10,
		CLK_INTERNAL_RC_OSCILLATOR = 2'b11
	} flfp_clk_e;
	typedef enum logic [1:0] {
		PROT_NONE = 2'b00,
		PROT_L1 = 2'b01,
		PROT_L2 = 2'b10,
		PROT_L3 = 2'b11
	} flfp_lvl_e;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_PROG = 2'b01,
		ST_ERASE = 2'b10
	} flfp_st_e;
	localparam logic [1:0] SP_CODE = 2'd0;
	localparam logic [1:0] SP_DATA = 2'd1;
	localparam logic [1:0] SP_SIG = 2'd2;
endpackage
`default_nettype wire

// File: design/flfp_top.sv
// Function
// - During programming, reading the last written byte returns it with MSB inverted.
// - During erase, polling reads return 7Fh since expected value is FFh.
// - Polling reference is the last byte loaded, not highest page address.
// - Two lock bytes, each either FFh unprogrammed or 00h programmed.
// - Only chip erase restores lock bytes to FFh.
// - Level from lock bytes: FF/FF level 1, 00/FF level 2, 00/00 level 3.
// - Level 2 rejects external programming of all spaces, signature and fuses.
// - Level 3 adds blocked code/data reads and disabled debug; fuses, signatures readable.
// - Application self-writes ignore the lock level.
// - Writing 00h clears a fuse; writing FFh leaves it unchanged.
// - Fuses return to FFh only via row erase by auto-erase fuse write.
// - All fuses default to FFh.
// - Two clock-source fuses select crystal high/low speed, external clock or RC.
// - Two startup fuses select wake-up delay per clock source class.
// - Reset-pin fuse FFh keeps pin as reset, 00h makes it general I/O.
// - Brown-out fuse FFh enables detector, 00h disables it.
// - Debug fuse inverted: FFh disables debug, 00h enables it.
// - Serial-programming fuse picks entry anytime or only at power-on reset.
// - Port-start fuse FFh tristates ports after reset, 00h quasi-bidirectional.
// - Clock-source and startup fuse changes apply only after power-on reset.
// - Reset-pin and serial-programming fuse changes apply when session ends with pin high.
// - Each fuse/lock address holds one bit; only 00h or FFh data used.
// - Auto-erase fuse write opcode F1h erases and rewrites the fuse row.
// - Signature writes accepted only while signature-programming fuse is enabled.
`default_nettype none
module flfp_top
	import flfp_pkg::*;
#(
	parameter int MEM_AW = 4,
	parameter int PROG_CYCLES = 64,
	parameter int ERASE_CYCLES = 128
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic rst_pin_n_i,
	input wire logic app_wr_i,
	input wire logic [1:0] app_space_i,
	input wire logic [MEM_AW-1:0] app_addr_i,
	input wire logic [7:0] app_data_i,
	output logic busy_o,
	output logic [1:0] protection_level_o,
	output logic [1:0] clock_source_sel_o,
	output logic [1:0] startup_delay_sel_o,
	output logic [15:0] startup_delay_us_o,
	output logic reset_pin_enable_o,
	output logic brownout_detector_enable_o,
	output logic on_chip_debug_enable_o,
	output logic serial_programming_mode_anytime_o,
	output logic ports_tristate_o,
	output logic user_sig_write_enable_o,
	output logic application_flash_write_enable_o
);
	localparam int DEPTH = 1 << MEM_AW;
	localparam logic [15:0] PROG_LOAD = 16'(PROG_CYCLES - 1);
	localparam logic [15:0] ERASE_LOAD = 16'(ERASE_CYCLES - 1);

	// ====================================================================
	// State
	typedef struct packed {
		logic ack;
		logic [31:0] dat;
		flfp_st_e st;
		logic [15:0] cnt;
		logic [2:0][DEPTH-1:0][7:0] mem;
		logic [DEPTH-1:0][7:0] pbuf;
		logic [DEPTH-1:0] pvld;
		logic [1:0] pspace;
		logic [MEM_AW-1:0] poll_addr;
		logic [1:0] poll_space;
		logic [7:0] poll_val;
		logic [NUM_FUSES-1:0] fuse;
		logic [NUM_LOCKS-1:0] lock;
		flfp_lvl_e lvl;
		logic [31:0] cmd;
		logic [7:0] rdata;
		logic refused, last_ae;
		flfp_clk_e clk_src;
		logic [1:0] sut;
		logic [15:0] sut_us;
		logic rst_pin_en, serial_any, bod_en, dbg_en, sig_en, port_tri, app_en;
		logic applied, busy;
		logic sync1, sync2, sync3;
	} flfp_state_s;

	flfp_state_s q, n;

	logic req, wr_cmd, is_mem_wr, is_mem_rd, accept;
	logic [7:0] op, cadr, cdat, rd;
	logic [MEM_AW-1:0] ma;
	logic [1:0] sp;
	logic [31:0] status, cfg;

	// ====================================================================
	// Next state
	always_comb begin
		n = q;
		req = wb_cyc_i & wb_stb_i & ~q.ack;
		wr_cmd = req & wb_we_i & (wb_adr_i == ADR_CMD) & (&wb_sel_i[2:0]);
		op = wb_dat_i[CMD_OP_LSB +: 8];
		cadr = wb_dat_i[CMD_ADR_LSB +: 8];
		cdat = wb_dat_i[CMD_DAT_LSB +: 8];
		ma = cadr[MEM_AW-1:0];
		sp = SP_CODE;
		is_mem_wr = 1'b0;
		is_mem_rd = 1'b0;
		accept = 1'b0;
		rd = BYTE_ERASED;
		n.ack = req;
		// Pin passes two flops; third stage only feeds the edge compare
		n.sync1 = rst_pin_n_i;
		n.sync2 = q.sync1;
		n.sync3 = q.sync2;
		unique case (op)
			OP_WR_CODE, OP_WR_CODE_AE: is_mem_wr = 1'b1;
			OP_WR_DATA, OP_WR_DATA_AE: {sp, is_mem_wr} = {SP_DATA, 1'b1};
			OP_WR_SIG, OP_WR_SIG_AE: {sp, is_mem_wr} = {SP_SIG, 1'b1};
			OP_RD_CODE: is_mem_rd = 1'b1;
			OP_RD_DATA: {sp, is_mem_rd} = {SP_DATA, 1'b1};
			OP_RD_SIG: {sp, is_mem_rd} = {SP_SIG, 1'b1};
			default: sp = SP_CODE;
		endcase
		// Programming or erase cycle completion
		if (q.st != ST_IDLE) begin
			if (q.cnt == 16'h0000) begin
				if (q.st == ST_PROG) begin
					for (int i = 0; i < DEPTH; i++) begin
						if (q.pvld[i]) begin
							n.mem[q.pspace][i] = q.pbuf[i];
						end
					end
					n.pvld = '0;
				end else begin
					n.mem[SP_CODE] = {DEPTH{BYTE_ERASED}};
					n.mem[SP_DATA] = {DEPTH{BYTE_ERASED}};
					if (q.sig_en) begin
						n.mem[SP_SIG] = {DEPTH{BYTE_ERASED}};
					end
					n.lock = LOCK_RESET;
				end
				n.st = ST_IDLE;
			end else begin
				n.cnt = q.cnt - 16'h0001;
			end
		end
		// Application self-write ignores lock level
		if (app_wr_i && q.st == ST_IDLE && (app_space_i == SP_DATA || q.app_en)) begin
			n.mem[app_space_i][app_addr_i] = app_data_i;
		end
		// Command execution
		if (wr_cmd) begin
			n.cmd = wb_dat_i;
			if (op == OP_CHIP_ERASE) begin
				accept = (q.st == ST_IDLE);
				if (accept) begin
					n.st = ST_ERASE;
					n.cnt = ERASE_LOAD;
				end
			end else if (op == OP_LOAD) begin
				accept = (q.st == ST_IDLE) && (q.lvl == PROT_L1);
				if (accept) begin
					n.pbuf[ma] = cdat;
					n.pvld[ma] = 1'b1;
				end
			end else if (is_mem_wr) begin
				accept = (q.st == ST_IDLE) && (q.lvl == PROT_L1)
					&& (sp != SP_SIG || q.sig_en);
				if (accept) begin
					n.pbuf[ma] = cdat;
					n.pvld[ma] = 1'b1;
					n.pspace = sp;
					n.poll_space = sp;
					n.poll_addr = ma;
					n.poll_val = cdat;
					n.st = ST_PROG;
					n.cnt = PROG_LOAD;
				end
			end else if (is_mem_rd) begin
				accept = 1'b1;
				if (q.lvl == PROT_L3 && sp != SP_SIG) begin
					rd = BYTE_ERASED;
				end else if (q.st == ST_ERASE) begin
					rd = POLL_ERASE;
				end else if (q.st == ST_PROG && sp == q.poll_space && ma == q.poll_addr) begin
					rd = q.poll_val ^ MSB_MASK;
				end else begin
					rd = q.mem[sp][ma];
				end
				n.rdata = rd;
			end else if (op == OP_WR_FUSE || op == OP_WR_FUSE_AE) begin
				accept = (q.lvl == PROT_L1) && (cadr < 8'(NUM_FUSES));
				if (accept) begin
					// Row erase at the start of an auto-erase sweep
					if (op == OP_WR_FUSE_AE && cadr == 8'h00) begin
						n.fuse = FUSE_RESET;
					end
					if (op == OP_WR_FUSE_AE && (cadr == 8'h00 || q.last_ae)) begin
						n.fuse[cadr[3:0]] = (cdat != BYTE_CLEARED);
					end else if (cdat == BYTE_CLEARED) begin
						n.fuse[cadr[3:0]] = 1'b0;
					end
					n.last_ae = (op == OP_WR_FUSE_AE);
				end
			end else if (op == OP_WR_LOCK) begin
				// Lock writes stay open so level 2 can still go to level 3
				accept = (cadr < 8'(NUM_LOCKS));
				if (accept && cdat == BYTE_CLEARED) begin
					n.lock[cadr[0]] = 1'b0;
				end
			end else if (op == OP_RD_FUSE) begin
				accept = 1'b1;
				n.rdata = (cadr < 8'(NUM_FUSES) && !q.fuse[cadr[3:0]]) ? BYTE_CLEARED
					: BYTE_ERASED;
			end else if (op == OP_RD_LOCK) begin
				accept = 1'b1;
				n.rdata = (cadr < 8'(NUM_LOCKS) && !q.lock[cadr[0]]) ? BYTE_CLEARED
					: BYTE_ERASED;
			end
			if (op != OP_WR_FUSE && op != OP_WR_FUSE_AE) begin
				n.last_ae = 1'b0;
			end
			n.refused = ~accept;
		end
		n.busy = (n.st != ST_IDLE);
		// Protection level decode
		unique case (n.lock)
			2'b11: n.lvl = PROT_L1;
			2'b10: n.lvl = PROT_L2;
			2'b01: n.lvl = PROT_L2;
			2'b00: n.lvl = PROT_L3;
		endcase
		// Live fuse effects
		n.bod_en = q.fuse[FUSE_BROWNOUT];
		n.dbg_en = ~q.fuse[FUSE_DEBUG] & (q.lvl != PROT_L3);
		n.port_tri = q.fuse[FUSE_TRISTATE];
		n.sig_en = ~q.fuse[FUSE_SIG_PROG];
		n.app_en = ~q.fuse[FUSE_APP_WRITE];
		// Clock and startup apply once, right after power-on reset
		if (!q.applied) begin
			n.applied = 1'b1;
			n.clk_src = flfp_clk_e'({q.fuse[FUSE_CS_HI], q.fuse[FUSE_CS_LO]});
			n.sut = {q.fuse[FUSE_SUT_HI], q.fuse[FUSE_SUT_LO]};
		end
		n.sut_us = (q.clk_src[1] == 1'b0) ? SUT_CRYSTAL_OSCILLATOR_US[q.sut] : SUT_OTHER_US[q.sut];
		// Reset-pin and entry fuses apply at power-on or at session end
		if (!q.applied || (q.sync2 && !q.sync3)) begin
			n.rst_pin_en = q.fuse[FUSE_RST_PIN];
			n.serial_any = q.fuse[FUSE_SERIAL_PROG];
		end
		// Bus read mux
		status = '0;
		status[STAT_BUSY] = (q.st != ST_IDLE);
		status[STAT_REFUSED] = q.refused;
		status[STAT_LVL_LSB +: 2] = q.lvl;
		status[STAT_ERASE] = (q.st == ST_ERASE);
		cfg = '0;
		cfg[CFG_CLK_LSB +: 2] = q.clk_src;
		cfg[CFG_SUT_LSB +: 2] = q.sut;
		cfg[CFG_RST_PIN] = q.rst_pin_en;
		cfg[CFG_BROWNOUT] = q.bod_en;
		cfg[CFG_DEBUG] = q.dbg_en;
		cfg[CFG_SERIAL_ANY] = q.serial_any;
		cfg[CFG_SIG_WR] = q.sig_en;
		cfg[CFG_TRISTATE] = q.port_tri;
		cfg[CFG_APP_WR] = q.app_en;
		if (req && !wb_we_i) begin
			unique case (wb_adr_i)
				ADR_CMD: n.dat = q.cmd;
				ADR_RDATA: n.dat = {24'h00_0000, q.rdata};
				ADR_STATUS: n.dat = status;
				ADR_CFG: n.dat = cfg;
				default: n.dat = 32'h0000_0000;
			endcase
		end
	end

	// ====================================================================
	// Registers; nonvolatile rows start erased at power-on
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= '0;
			q.mem <= {(3 * DEPTH){BYTE_ERASED}};
			q.fuse <= FUSE_RESET;
			q.lock <= LOCK_RESET;
			q.lvl <= PROT_L1;
			q.clk_src <= CLK_INTERNAL_RC_OSCILLATOR;
			q.sut <= 2'b11;
			q.sut_us <= SUT_OTHER_US[3];
			{q.rst_pin_en, q.serial_any, q.bod_en, q.port_tri} <= 4'hf;
			{q.sync1, q.sync2, q.sync3} <= 3'h7;
		end else begin
			q <= n;
		end
	end

	assign wb_ack_o = q.ack;
	assign wb_dat_o = q.dat;
	assign busy_o = q.busy;
	assign protection_level_o = q.lvl;
	assign clock_source_sel_o = q.clk_src;
	assign startup_delay_sel_o = q.sut;
	assign startup_delay_us_o = q.sut_us;
	assign reset_pin_enable_o = q.rst_pin_en;
	assign brownout_detector_enable_o = q.bod_en;
	assign on_chip_debug_enable_o = q.dbg_en;
	assign serial_programming_mode_anytime_o = q.serial_any;
	assign ports_tristate_o = q.port_tri;
	assign user_sig_write_enable_o = q.sig_en;
	assign application_flash_write_enable_o = q.app_en;

	// ====================================================================
	// Assertions
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_rd_poll;
		wr_cmd && is_mem_rd && q.st == ST_PROG && q.lvl != PROT_L3
			&& sp == q.poll_space && ma == q.poll_addr;
	endsequence
	sequence s_rd_erase;
		wr_cmd && is_mem_rd && q.st == ST_ERASE && q.lvl != PROT_L3;
	endsequence

	a_ack_single_pulse: assert property (q.ack |=> !q.ack)
		else $error("ack held longer than one cycle");
	a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !q.ack |=> q.ack)
		else $error("request not answered next cycle");
	a_poll_inverted: assert property (s_rd_poll |=> q.rdata == ($past(q.poll_val) ^ MSB_MASK))
		else $error("polling read not msb inverted");
	a_erase_poll_val: assert property (s_rd_erase |=> q.rdata == POLL_ERASE)
		else $error("erase polling value wrong");
	a_lock_only_erase: assert property ($rose(q.lock[0]) || $rose(q.lock[1])
		|-> $past(q.st) == ST_ERASE && $past(q.cnt) == 16'h0000)
		else $error("lock restored outside chip erase");
	a_level_decode: assert property (##1 (q.lock == 2'b00) == (q.lvl == PROT_L3)
		&& (q.lock == 2'b11) == (q.lvl == PROT_L1))
		else $error("protection level mismatch");
	a_level2_no_fuse: assert property (q.lvl != PROT_L1 |=> $stable(q.fuse))
		else $error("fuse changed while protected");
	a_level3_reads: assert property (wr_cmd && op == OP_RD_CODE && q.lvl == PROT_L3
		|=> q.rdata == BYTE_ERASED)
		else $error("code read not blocked at level 3");
	a_debug_level3: assert property (q.lvl == PROT_L3 |=> !q.dbg_en)
		else $error("debug enabled at level 3");
	a_fuse_set_ae: assert property ($rose(q.fuse[FUSE_DEBUG])
		|-> $past(wr_cmd) && $past(op) == OP_WR_FUSE_AE)
		else $error("fuse set without auto-erase write");
	a_clk_por_only: assert property ($changed(q.clk_src) |-> !$past(q.applied))
		else $error("clock source changed after power-on");
	a_rst_pin_session: assert property ($changed(q.rst_pin_en)
		|-> $past(q.sync2) && !$past(q.sync3) || !$past(q.applied))
		else $error("reset pin fuse applied mid-session");
	a_sig_gate: assert property (wr_cmd && is_mem_wr && sp == SP_SIG && !q.sig_en
		|=> q.refused)
		else $error("signature write accepted while disabled");
endmodule // flfp_top
`default_nettype wire

// File: verification/flfp_prog_model.sv
`default_nettype none
// ====================================================================
// Programmer model: classic Wishbone master
module flfp_prog_model
	import flfp_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic wb_ack_i,
	input wire logic [31:0] wb_dat_i,
	output logic wb_cyc_o,
	output logic wb_stb_o,
	output logic wb_we_o,
	output logic [7:0] wb_adr_o,
	output logic [3:0] wb_sel_o,
	output logic [31:0] wb_dat_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic lock_set = 1'b0;
	initial begin
		wb_cyc_o = 1'b0;
		wb_stb_o = 1'b0;
		wb_we_o = 1'b0;
		wb_adr_o = 8'h00;
		wb_sel_o = 4'h0;
		wb_dat_o = 32'h0000_0000;
	end
	task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge core_clk_i);
		wb_cyc_o <= 1'b1;
		wb_stb_o <= 1'b1;
		wb_we_o <= we;
		wb_adr_o <= adr;
		wb_sel_o <= 4'hf;
		wb_dat_o <= wd;
		@(posedge core_clk_i);
		while (wb_ack_i !== 1'b1) @(posedge core_clk_i);
		rd = wb_dat_i;
		wb_cyc_o <= 1'b0;
		wb_stb_o <= 1'b0;
		wb_we_o <= 1'b0;
		// Released lines show garbage, not the last value
		wb_adr_o <= ~adr;
		wb_dat_o <= ~wd;
	endtask
	task automatic rd_reg(input logic [7:0] adr, output logic [31:0] rd);
		xfer(1'b0, adr, 32'h0000_0000, rd);
	endtask
	task automatic cmd(input logic [7:0] op, input logic [7:0] a, input logic [7:0] d);
		logic [31:0] rd;
		// Fuses are not touched after a lock write until the next chip erase
		if ((op == OP_WR_FUSE || op == OP_WR_FUSE_AE) && lock_set) return;
		if (op == OP_WR_LOCK) lock_set = 1'b1;
		if (op == OP_CHIP_ERASE) lock_set = 1'b0;
		xfer(1'b1, ADR_CMD, {8'h00, d, a, op}, rd);
	endtask
	task automatic bit_wr(input logic [7:0] op, input logic [7:0] a, input logic clr);
		cmd(op, a, clr ? BYTE_CLEARED : BYTE_ERASED);
	endtask
endmodule // flfp_prog_model
`default_nettype wire

// File: verification/tb_top.sv
`default_nettype none
module tb_top;
	import flfp_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, rst_n = 1'b0, pin_n = 1'b0, app_wr = 1'b0;
	logic cyc, stb, we, ack, busy, rpe, brownout_detector, dbg, spa, tri_o, sig_en, app_en;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, v;
	logic [1:0] lvl, cs, sut;
	logic [15:0] sut_us;
	int miscompares = 0, cmp_count = 0, cycles = 0;
	int fz[7] = '{0, 4, 5, 6, 7, 8, 9};
	initial forever #25 clk = ~clk;
	flfp_top #(.MEM_AW(4), .PROG_CYCLES(16), .ERASE_CYCLES(24)) dut (.core_clk_i(clk),
		.rst_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.rst_pin_n_i(pin_n), .app_wr_i(app_wr), .app_space_i(SP_DATA),
		.app_addr_i(4'h3), .app_data_i(8'h5a), .busy_o(busy), .protection_level_o(lvl),
		.clock_source_sel_o(cs), .startup_delay_sel_o(sut), .startup_delay_us_o(sut_us),
		.reset_pin_enable_o(rpe), .brownout_detector_enable_o(brownout_detector),
		.on_chip_debug_enable_o(dbg), .serial_programming_mode_anytime_o(spa),
		.ports_tristate_o(tri_o), .user_sig_write_enable_o(sig_en),
		.application_flash_write_enable_o(app_en));
	flfp_prog_model prog (.core_clk_i(clk), .wb_ack_i(ack), .wb_dat_i(rdat),
		.wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel),
		.wb_dat_o(wdat));
	// ====================================================================
	// Helpers
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic finish_test;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic rd_chk(input string name, input logic [7:0] op, input logic [7:0] a,
		input logic [7:0] exp);
		prog.cmd(op, a, 8'h00);
		prog.rd_reg(ADR_RDATA, v);
		check(name, {24'h0000_00, exp}, {24'h0000_00, v[7:0]});
	endtask
	task automatic st_chk(input string name, input logic [4:0] exp);
		prog.rd_reg(ADR_STATUS, v);
		check(name, {27'h000_0000, exp}, {27'h000_0000, v[4:0]});
	endtask
	task automatic wait_idle;
		for (int i = 0; i < 40; i++) begin
			prog.rd_reg(ADR_STATUS, v);
			if (v[0] === 1'b0) return;
		end
		check("busy timeout", 32'h0000_0000, 32'h0000_0001);
	endtask
	// Long waits are cut short here and by the 40-poll limit in wait_idle
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			$display("run timed out");
			finish_test();
		end
	end
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		// ====================================================================
		// Reset state
		prog.rd_reg(ADR_CFG, v);
		check("cfg", 32'h0000_02bf, {21'h00_0000, v[10:0]});
		check("sut", {11'h000, 2'b11, 1'b0, 2'b11, SUT_OTHER_US[3]}, {11'h000, cs, app_en, sut, sut_us});
		st_chk("status", 5'h04);
		prog.rd_reg(8'h10, v);
		check("unmapped", 32'h0000_0000, v);
		for (int i = 0; i < NUM_FUSES; i++) rd_chk("fuse", OP_RD_FUSE, i[7:0], 8'hff);
		for (int i = 0; i < NUM_LOCKS; i++) rd_chk("lock", OP_RD_LOCK, i[7:0], 8'hff);
		prog.cmd(OP_WR_SIG, 8'h01, 8'h33);
		st_chk("sig refused", 5'h06);
		$display("test reset done");
		// ====================================================================
		// Fuse clearing and deferred effect
		foreach (fz[i]) prog.bit_wr(OP_WR_FUSE, 8'(fz[i]), 1'b1);
		rd_chk("fuse0", OP_RD_FUSE, 8'h00, 8'h00);
		prog.bit_wr(OP_WR_FUSE, 8'h00, 1'b0);
		rd_chk("fuse0 ff", OP_RD_FUSE, 8'h00, 8'h00);
		st_chk("refuse cleared", 5'h04);
		repeat (2) @(posedge clk);
		check("outs", 32'h0000_005f, {24'h0000_00, brownout_detector, dbg, tri_o, sig_en, cs, rpe, spa});
		pin_n <= 1'b1;
		repeat (6) @(posedge clk);
		check("session end", 32'h0000_0000, {30'h0000_0000, rpe, spa});
		pin_n <= 1'b0;
		repeat (4) @(posedge clk);
		prog.cmd(OP_WR_SIG, 8'h01, 8'h33);
		wait_idle();
		rd_chk("sig", OP_RD_SIG, 8'h01, 8'h33);
		$display("test fuses done");
		// ====================================================================
		// Completion polling
		prog.cmd(OP_LOAD, 8'h09, 8'h11);
		prog.cmd(OP_WR_CODE, 8'h05, 8'h3c);
		rd_chk("poll", OP_RD_CODE, 8'h05, 8'hbc);
		st_chk("busy", 5'h05);
		check("busy pin", 32'h0000_0001, {31'h0000_0000, busy});
		wait_idle();
		rd_chk("true5", OP_RD_CODE, 8'h05, 8'h3c);
		rd_chk("true9", OP_RD_CODE, 8'h09, 8'h11);
		$display("test polling done");
		// ====================================================================
		// Locks, levels and chip erase
		prog.bit_wr(OP_WR_LOCK, 8'h00, 1'b1);
		st_chk("level2", 5'h08);
		prog.cmd(OP_WR_CODE, 8'h03, 8'h44);
		st_chk("code refused", 5'h0a);
		prog.cmd(OP_WR_SIG, 8'h02, 8'h55);
		st_chk("sig refused2", 5'h0a);
		@(posedge clk);
		app_wr <= 1'b1;
		@(posedge clk);
		app_wr <= 1'b0;
		wait_idle();
		rd_chk("app data", OP_RD_DATA, 8'h03, 8'h5a);
		prog.bit_wr(OP_WR_LOCK, 8'h01, 1'b1);
		st_chk("level3", 5'h0c);
		check("dbg l3", 32'h0000_0000, {31'h0000_0000, dbg});
		rd_chk("code l3", OP_RD_CODE, 8'h05, 8'hff);
		rd_chk("fuse l3", OP_RD_FUSE, 8'h00, 8'h00);
		rd_chk("sig l3", OP_RD_SIG, 8'h01, 8'h33);
		prog.bit_wr(OP_WR_LOCK, 8'h00, 1'b0);
		rd_chk("lock kept", OP_RD_LOCK, 8'h00, 8'h00);
		prog.cmd(OP_CHIP_ERASE, 8'h00, 8'h00);
		rd_chk("erase poll", OP_RD_SIG, 8'h01, POLL_ERASE);
		prog.rd_reg(ADR_STATUS, v);
		check("erasing", 32'h0000_0003, {30'h0000_0000, v[STAT_ERASE], v[STAT_BUSY]});
		wait_idle();
		for (int i = 0; i < NUM_LOCKS; i++) rd_chk("lock erased", OP_RD_LOCK, i[7:0], 8'hff);
		check("level1", 32'h0000_0009, {27'h000_0000, lvl, 2'b00, dbg});
		$display("test locks done");
		// ====================================================================
		// Auto-erasing fuse write
		prog.bit_wr(OP_WR_FUSE_AE, 8'h00, 1'b0);
		prog.bit_wr(OP_WR_FUSE_AE, 8'h01, 1'b1);
		rd_chk("ae fuse1", OP_RD_FUSE, 8'h01, 8'h00);
		rd_chk("ae fuse6", OP_RD_FUSE, 8'h06, 8'hff);
		rd_chk("ae fuse0", OP_RD_FUSE, 8'h00, 8'hff);
		repeat (2) @(posedge clk);
		check("dbg off", 32'h0000_0000, {31'h0000_0000, dbg});
		$display("test auto erase done");
		finish_test();
	end
endmodule // tb_top
`default_nettype wire
